// >>> smc_defines.vh
// constants for the sdram clock, refresh and configuration control block
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH
// offsets inside the 100h controller window (base + 8400h)
`define SMC_CTRL1_OFFSET 8'h00
`define SMC_CTRL2_OFFSET 8'h04
`define SMC_CTRL1_ABS 16'h8400
`define SMC_CTRL1_RESET 32'h248c0040
`define SMC_CTRL2_RESET 32'h00000801
// memory_control_one fields
`define SMC_DIV_MSB 20
`define SMC_DIV_LSB 18
`define SMC_START_BIT 17
`define SMC_RFSH_MSB 16
`define SMC_RFSH_LSB 8
`define SMC_STAG_MSB 7
`define SMC_STAG_LSB 6
`define SMC_EARLY_BIT 5
`define SMC_TEST_BIT 4
`define SMC_ARB_BIT 3
`define SMC_SMM_BIT 2
`define SMC_PROG_BIT 0
// second control register shift field
`define SMC_SHIFT_MSB 5
`define SMC_SHIFT_LSB 3
`define SMC_SHIFT_RSVD 3'h7
// refresh interval unit in core clocks (log2 of 64)
`define SMC_RFSH_UNIT_LOG2 6
// divide ratio in half core clocks is code + this offset
`define SMC_DIV_HALF_OFS 4'h3
// smm window
`define SMC_SMM_WIN_BASE 32'h00400000
`define SMC_SMM_WIN_SIZE 32'h00020000
`define SMC_SMM_PHYS_BASE 32'h000a0000
`endif

// >>> smc_ctrl.v
// sdram clock generator, refresh scheduler, arbiter and control register
// ======================================================================
// Functional notes
// - The sdram clock is the core clock divided by 2 to 5 in half steps, code 000 reserved and 011 default.
// - A new divide select does not touch the running clock until the start bit rises.
// - Software writes the start bit 0 then 1 and the clock starts with the new ratio and shift on that rise.
// - Refresh happens every interval times 64 core clocks, and an interval of zero disables it.
// - Bank refreshes are spaced by 0, 1, 2 or 4 sdram clocks for stagger codes 00 to 11, default 01.
// - With early address setup set, the address leads chip select by one extra clock.
// - Writing the test refresh bit from 0 to 1 raises a refresh request outside the interval timer.
// - Arbitration bit 0 gives round robin among cpu, graphics and low display, bit 1 favours the cpu.
// - High priority display requests always win over every other requester.
// - With smm remap set, base plus 400000 maps onto physical A0000 to BFFFF.
// - A written 0 to 1 of the program bit issues a mode register set with the latency setting.
// - The 32-bit control register resets to 248C0040h and is readable and writable.
// - A three-bit clock shift lives in the second register and applies only on the next start rise.
`include "smc_defines.vh"
`default_nettype none

module smc_ctrl #(
  parameter RFSH_W = 9
) (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire reg_sel_in,
  input wire reg_wr_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  output reg [31:0] reg_rdata_out,
  input wire [2:0] cas_latency_setting_in,
  input wire req_disp_high_in,
  input wire req_cpu_in,
  input wire req_gfx_in,
  input wire req_disp_low_in,
  input wire [31:0] smm_offset_in,
  output reg [1:0] sdram_clock_pair_out,
  output reg sdram_clock_tick_out,
  output reg [3:0] bank_refresh_out,
  output reg refresh_busy_out,
  output reg mode_set_out,
  output reg [2:0] mode_latency_out,
  output reg early_address_setup_out,
  output reg [3:0] grant_out,
  output reg smm_hit_out,
  output reg [31:0] smm_phys_out
);

  // ====================================================================
  // helpers
  function [3:0] wrap_mod;
    input [4:0] v;
    input [3:0] n;
    reg [4:0] t;
    integer i;
    begin
      t = v;
      for (i = 0; i < 3; i = i + 1) begin
        if (t >= {1'b0, n}) begin
          t = t - {1'b0, n};
        end
      end
      wrap_mod = t[3:0];
    end
  endfunction

  function half_level;
    input [3:0] h;
    input [3:0] n;
    input [2:0] sh;
    reg [3:0] pos;
    reg [3:0] hi_len;
    begin
      pos = wrap_mod({1'b0, h} + {n, 1'b0} - {2'b00, sh}, n);
      hi_len = (n + 4'h1) >> 1;
      half_level = (pos < hi_len);
    end
  endfunction

  // ====================================================================
  // register file
  reg [31:0] ctrl1_reg;
  reg [31:0] ctrl2_reg;
  wire wr_ctrl1 = reg_sel_in && reg_wr_in && (reg_addr_in == `SMC_CTRL1_OFFSET);
  wire wr_ctrl2 = reg_sel_in && reg_wr_in && (reg_addr_in == `SMC_CTRL2_OFFSET);
  wire start_rise = wr_ctrl1 && reg_wdata_in[`SMC_START_BIT] && !ctrl1_reg[`SMC_START_BIT];
  wire prog_rise = wr_ctrl1 && reg_wdata_in[`SMC_PROG_BIT] && !ctrl1_reg[`SMC_PROG_BIT];
  wire test_rise = wr_ctrl1 && reg_wdata_in[`SMC_TEST_BIT] && !ctrl1_reg[`SMC_TEST_BIT];
  wire start_fall = wr_ctrl1 && !reg_wdata_in[`SMC_START_BIT];

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl1_reg <= `SMC_CTRL1_RESET;
      ctrl2_reg <= `SMC_CTRL2_RESET;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_reg <= reg_wdata_in;
      end
      if (wr_ctrl2) begin
        ctrl2_reg <= reg_wdata_in;
      end
    end
  end

  always @* begin
    if (reg_addr_in == `SMC_CTRL1_OFFSET) begin
      reg_rdata_out = ctrl1_reg;
    end else if (reg_addr_in == `SMC_CTRL2_OFFSET) begin
      reg_rdata_out = ctrl2_reg;
    end else begin
      reg_rdata_out = 32'h00000000;
    end
  end

  // ====================================================================
  // sdram clock generator, half core clock resolution
  reg run_reg;
  reg [3:0] div_half_reg;
  reg [2:0] shift_reg;
  reg [3:0] ph_reg;
  wire [2:0] div_code = reg_wdata_in[`SMC_DIV_MSB:`SMC_DIV_LSB];
  wire [2:0] sh_code = ctrl2_reg[`SMC_SHIFT_MSB:`SMC_SHIFT_LSB];
  wire [3:0] ph_next = wrap_mod({1'b0, ph_reg} + 5'h02, div_half_reg);
  wire [3:0] ph_odd = wrap_mod({1'b0, ph_next} + 5'h01, div_half_reg);

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_reg <= 1'b0;
      div_half_reg <= 4'h6;
      shift_reg <= 3'h0;
      ph_reg <= 4'h0;
      sdram_clock_pair_out <= 2'b00;
      sdram_clock_tick_out <= 1'b0;
    end else begin
      if (start_rise) begin
        run_reg <= 1'b1;
        // reserved code 000 keeps the previous ratio
        if (div_code != 3'h0) begin
          div_half_reg <= {1'b0, div_code} + `SMC_DIV_HALF_OFS;
        end
        shift_reg <= (sh_code == `SMC_SHIFT_RSVD) ? 3'h0 : sh_code;
        ph_reg <= 4'h0;
        sdram_clock_pair_out <= 2'b00;
        sdram_clock_tick_out <= 1'b0;
      end else if (start_fall || !run_reg) begin
        run_reg <= run_reg && !start_fall;
        ph_reg <= 4'h0;
        sdram_clock_pair_out <= 2'b00;
        sdram_clock_tick_out <= 1'b0;
      end else begin
        ph_reg <= ph_next;
        // bit0 is the rising-edge half, bit1 the falling-edge half
        sdram_clock_pair_out[0] <= half_level(ph_next, div_half_reg, shift_reg);
        sdram_clock_pair_out[1] <= half_level(ph_odd, div_half_reg, shift_reg);
        sdram_clock_tick_out <= (ph_next < 4'h2);
      end
    end
  end

  // ====================================================================
  // refresh interval timer and staggered bank refresh
  reg [RFSH_W+`SMC_RFSH_UNIT_LOG2-1:0] rfsh_cnt_reg;
  reg rfsh_pend_reg;
  reg [1:0] bank_reg;
  reg [2:0] gap_reg;
  wire [RFSH_W-1:0] interval = ctrl1_reg[`SMC_RFSH_MSB:`SMC_RFSH_LSB];
  wire [RFSH_W+`SMC_RFSH_UNIT_LOG2-1:0] limit = {interval, {`SMC_RFSH_UNIT_LOG2{1'b0}}};
  wire timer_hit = (interval != {RFSH_W{1'b0}}) && (rfsh_cnt_reg >= limit - 1'b1);
  wire [1:0] stag = ctrl1_reg[`SMC_STAG_MSB:`SMC_STAG_LSB];
  wire [2:0] stag_clks = (stag == 2'b11) ? 3'h4 : {1'b0, stag};
  wire tick = sdram_clock_tick_out;

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rfsh_cnt_reg <= {(RFSH_W+`SMC_RFSH_UNIT_LOG2){1'b0}};
      rfsh_pend_reg <= 1'b0;
      refresh_busy_out <= 1'b0;
      bank_reg <= 2'b00;
      gap_reg <= 3'h0;
      bank_refresh_out <= 4'h0;
    end else begin
      bank_refresh_out <= 4'h0;
      if (interval == {RFSH_W{1'b0}} || timer_hit) begin
        rfsh_cnt_reg <= {(RFSH_W+`SMC_RFSH_UNIT_LOG2){1'b0}};
      end else begin
        rfsh_cnt_reg <= rfsh_cnt_reg + 1'b1;
      end
      if (timer_hit || test_rise) begin
        rfsh_pend_reg <= 1'b1;
      end else if (!refresh_busy_out && rfsh_pend_reg) begin
        rfsh_pend_reg <= 1'b0;
      end
      if (!refresh_busy_out) begin
        if (rfsh_pend_reg) begin
          refresh_busy_out <= 1'b1;
          bank_reg <= 2'b00;
          gap_reg <= 3'h0;
        end
      end else if (tick) begin
        if (gap_reg != 3'h0) begin
          gap_reg <= gap_reg - 3'h1;
        end else if (stag_clks == 3'h0) begin
          bank_refresh_out <= 4'hf;
          refresh_busy_out <= 1'b0;
        end else begin
          bank_refresh_out <= 4'h1 << bank_reg;
          bank_reg <= bank_reg + 2'b01;
          gap_reg <= stag_clks - 3'h1;
          if (bank_reg == 2'b11) begin
            refresh_busy_out <= 1'b0;
          end
        end
      end
    end
  end

  // ====================================================================
  // mode register set and early address setup
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_set_out <= 1'b0;
      mode_latency_out <= 3'h0;
      early_address_setup_out <= 1'b0;
    end else begin
      mode_set_out <= prog_rise;
      if (prog_rise) begin
        mode_latency_out <= cas_latency_setting_in;
      end
      early_address_setup_out <= ctrl1_reg[`SMC_EARLY_BIT];
    end
  end

  // ====================================================================
  // internal bus arbiter: grant bits are high display, cpu, gfx, low display
  reg [1:0] rr_reg;
  reg [3:0] grant_next;
  reg [1:0] rr_next;
  wire [2:0] rr_req = {req_disp_low_in, req_gfx_in, req_cpu_in};
  wire cpu_first = ctrl1_reg[`SMC_ARB_BIT];
  integer k;
  reg [1:0] idx;
  reg [2:0] sum;
  reg found;

  always @* begin
    grant_next = 4'h0;
    rr_next = rr_reg;
    found = 1'b0;
    idx = 2'b00;
    sum = 3'h0;
    if (req_disp_high_in) begin
      grant_next = 4'h1;
    end else if (cpu_first && req_cpu_in) begin
      grant_next = 4'h2;
    end else begin
      for (k = 0; k < 3; k = k + 1) begin
        sum = {1'b0, rr_reg} + {1'b0, k[1:0]};
        idx = (sum > 3'd2) ? sum[1:0] + 2'd1 : sum[1:0];
        if (!found && rr_req[idx] && !(cpu_first && idx == 2'd0)) begin
          found = 1'b1;
          grant_next = 4'h2 << idx;
          rr_next = (idx == 2'd2) ? 2'd0 : idx + 2'd1;
        end
      end
    end
  end

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rr_reg <= 2'd0;
      grant_out <= 4'h0;
    end else begin
      rr_reg <= rr_next;
      grant_out <= grant_next;
    end
  end

  // ====================================================================
  // smm window remap
  wire [31:0] smm_rel = smm_offset_in - `SMC_SMM_WIN_BASE;
  wire in_win = (smm_offset_in >= `SMC_SMM_WIN_BASE) && (smm_rel < `SMC_SMM_WIN_SIZE);

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      smm_hit_out <= 1'b0;
      smm_phys_out <= 32'h00000000;
    end else begin
      smm_hit_out <= ctrl1_reg[`SMC_SMM_BIT] && in_win;
      smm_phys_out <= (ctrl1_reg[`SMC_SMM_BIT] && in_win) ?
                      `SMC_SMM_PHYS_BASE + smm_rel : 32'h00000000;
    end
  end

endmodule // smc_ctrl
`default_nettype wire

// >>> smc_sdram.sv
// sdram device model: counts bank refreshes and captures mode set latency
`default_nettype none
module smc_sdram (
  input wire logic clk_in,
  input wire logic [3:0] rfsh_in,
  input wire logic mrs_in,
  input wire logic [2:0] lat_in,
  output var int rfsh_cnt_out,
  output var logic [2:0] lat_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rfsh_cnt_out = 0;
  initial lat_out = 3'h0;
  // ======================================
  // one refresh per pulsed bank
  always @(posedge clk_in) begin
    if (rfsh_in != 4'h0) rfsh_cnt_out <= rfsh_cnt_out + $countones(rfsh_in);
    if (mrs_in) lat_out <= lat_in;
  end
endmodule // smc_sdram
`default_nettype wire

// >>> smc_ctrl_chk.sv
// port assertions for the sdram control block
`default_nettype none
module smc_chk (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [2:0] cas_latency_setting_in,
  input wire logic req_disp_high_in,
  input wire logic req_cpu_in,
  input wire logic [31:0] smm_offset_in,
  input wire logic [1:0] sdram_clock_pair_out,
  input wire logic [3:0] bank_refresh_out,
  input wire logic mode_set_out,
  input wire logic [2:0] mode_latency_out,
  input wire logic early_address_setup_out,
  input wire logic [3:0] grant_out,
  input wire logic smm_hit_out,
  input wire logic [31:0] smm_phys_out
);
  wire logic rd = reg_addr_in == 8'h00 && !reg_wr_in;
  wire logic wr = reg_sel_in && reg_wr_in && reg_addr_in == 8'h00;
  wire logic [31:0] r = reg_rdata_out;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // ======================================
  // assertions
  property p_mrs;
    wr && reg_wdata_in[0] && !r[0] |=>
      mode_set_out && mode_latency_out == $past(cas_latency_setting_in);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode set missing");
  property p_early;
    rd && $past(rd) |-> early_address_setup_out == r[5];
  endproperty
  a_early: assert property (p_early) else $error("early setup wrong");
  property p_hi;
    req_disp_high_in |=> grant_out == 4'h1;
  endproperty
  a_hi: assert property (p_hi) else $error("high display not first");
  property p_cpu;
    rd && r[3] && req_cpu_in && !req_disp_high_in |=> grant_out == 4'h2;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu not favoured");
  property p_smm;
    rd && r[2] && smm_offset_in[31:17] == 15'h0020 |=>
      smm_hit_out && smm_phys_out == $past(smm_offset_in) - 32'h00360000;
  endproperty
  a_smm: assert property (p_smm) else $error("smm remap wrong");
  property p_stop;
    rd && $past(rd) && !r[17] |=> sdram_clock_pair_out == 2'b00;
  endproperty
  a_stop: assert property (p_stop) else $error("clock not stopped");
  property p_rst;
    $rose(nrst_in) && reg_addr_in == 8'h00 |-> r == 32'h248c0040;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_bank;
    bank_refresh_out != 4'h0 |-> $onehot(bank_refresh_out) || bank_refresh_out == 4'hf;
  endproperty
  a_bank: assert property (p_bank) else $error("bank pulses wrong");
endmodule // smc_chk
bind smc_ctrl smc_chk chk_u (.*);
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the sdram control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 0, nrst_in = 0, sel = 0, wen = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, d, ofs = 32'h0;
  logic [2:0] lat = 3'h0;
  logic [3:0] req = 4'h0;
  wire logic [31:0] rdat, phys;
  wire logic [1:0] pair;
  wire logic [3:0] bank, gnt;
  wire logic tick, busy, mset, early, hit;
  wire logic [2:0] mlat, plat;
  int rcnt, c, h, i, error_cnt = 0, checks_done = 0;
  localparam logic [31:0] B = 32'h00060000;
  // {code, cycles of two periods, high halves in them}
  logic [15:0] rows [7] = '{16'h1404, 16'h2506, 16'h3606, 16'h4708, 16'h5808, 16'h690a, 16'h7a0a};
  initial forever #2 clk_sys_in = ~clk_sys_in;
  smc_ctrl dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_sel_in(sel), .reg_wr_in(wen),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdat), .cas_latency_setting_in(lat),
    .req_disp_high_in(req[0]), .req_cpu_in(req[1]), .req_gfx_in(req[2]), .req_disp_low_in(req[3]),
    .smm_offset_in(ofs), .sdram_clock_pair_out(pair), .sdram_clock_tick_out(tick),
    .bank_refresh_out(bank), .refresh_busy_out(busy), .mode_set_out(mset),
    .mode_latency_out(mlat), .early_address_setup_out(early), .grant_out(gnt),
    .smm_hit_out(hit), .smm_phys_out(phys));
  smc_sdram sd_u (.clk_in(clk_sys_in), .rfsh_in(bank), .mrs_in(mset), .lat_in(mlat),
    .rfsh_cnt_out(rcnt), .lat_out(plat));
  // ======================================
  // tasks
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk_sys_in);
    {sel, wen, addr, wd} = {2'b11, a, v & 32'hffdfffff};
    @(negedge clk_sys_in);
    {sel, wen} = 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk_sys_in);
    addr = a;
    #1 chk(rdat, e);
  endtask
  task automatic wb(input logic [3:0] v, output int n);
    for (n = 0; bank !== v && n < 300; n++) @(negedge clk_sys_in);
    if (n == 300) begin
      chk(bank, v);
      print_verdict;
    end
  endtask
  task automatic per(output int n, output int ones);
    int k;
    k = 0;
    ones = 0;
    for (n = 0; tick !== 1'b1 && n < 40; n++) @(negedge clk_sys_in);
    for (n = 0; k < 2 && n < 40; n++) begin
      ones += pair[0] + pair[1];
      @(negedge clk_sys_in);
      k += tick;
    end
    if (n == 40) begin
      chk(n, 0);
      print_verdict;
    end
  endtask
  // ======================================
  // main sequence
  initial begin
    repeat (20) @(negedge clk_sys_in);
    nrst_in = 1;
    rd(8'h00, 32'h248c0040);
    rd(8'h04, 32'h00000801);
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h0);
    $display("reset test done");
    for (i = 0; i < 7; i++) begin
      d = {11'h0, rows[i][14:12], 12'h0, i[0], 5'h0};
      wr(8'h00, d);
      wr(8'h00, d | 32'h00020000);
      per(c, h);
      chk(c, rows[i][11:8]);
      chk(h, rows[i][7:0]);
    end
    rd(8'h00, d | 32'h00020000);
    $display("ratio table done");
    wr(8'h00, B);
    per(c, h);
    chk(c, 10);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h00020000);
    per(c, h);
    chk(c, 10);
    $display("ratio hold done");
    wr(8'h00, 32'h00040000);
    wr(8'h00, B | 32'h100);
    wb(4'hf, c);
    @(negedge clk_sys_in);
    wb(4'hf, c);
    chk(c + 1, 64);
    wr(8'h00, B);
    c = rcnt;
    repeat (200) @(negedge clk_sys_in);
    chk(rcnt - c, 0);
    $display("refresh interval done");
    for (i = 1; i < 4; i++) begin
      d = B | (i << 6);
      wr(8'h00, d);
      wr(8'h00, d | 32'h10);
      wb(4'h1, c);
      chk(busy, 1'b1);
      wb(4'h8, c);
      chk(busy, 1'b0);
      chk(c, 6 * (1 << (i - 1)));
    end
    $display("stagger done");
    lat = 3'h5;
    wr(8'h00, B);
    wr(8'h00, B | 32'h1);
    repeat (3) @(negedge clk_sys_in);
    chk(plat, 3'h5);
    $display("mode set done");
    h = 0;
    req = 4'he;
    repeat (3) begin
      @(negedge clk_sys_in);
      h |= gnt;
    end
    chk(h, 4'he);
    req = 4'h4;
    repeat (2) @(negedge clk_sys_in);
    chk(gnt, 4'h4);
    req = 4'he;
    wr(8'h00, B | 32'h8);
    repeat (2) @(negedge clk_sys_in);
    chk(gnt, 4'h2);
    req = 4'hf;
    repeat (2) @(negedge clk_sys_in);
    chk(gnt, 4'h1);
    $display("arbiter done");
    wr(8'h00, B | 32'h4);
    ofs = 32'h00410000;
    repeat (2) @(negedge clk_sys_in);
    chk(phys, 32'h000b0000);
    chk(hit, 1'b1);
    $display("smm done");
    wr(8'h04, 32'h00000811);
    per(c, h);
    chk(pair, 2'b11);
    wr(8'h00, 32'h00040000);
    wr(8'h00, B);
    per(c, h);
    chk(pair, 2'b00);
    $display("clock shift done");
    nrst_in = 0;
    #1 chk(rdat, 32'h248c0040);
    chk(pair, 2'b00);
    chk(gnt, 4'h0);
    repeat (3) @(negedge clk_sys_in);
    nrst_in = 1;
    rd(8'h04, 32'h00000801);
    wr(8'h00, 32'h00020000);
    per(c, h);
    chk(c, 6);
    chk(h, 6);
    $display("mid reset done");
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
